// *** design/gsict_pkg.sv ***
// constants shared by the gas sensor i2c command target
package gsict_pkg;
    // clock rate of core_clk
    localparam real CLK_MHZ = 25.0;
    // power-up / soft restart delay, longest and typical, in ms
    localparam real SOFT_RESTART_DELAY_MS = 0.6;
    localparam real SOFT_RESTART_TYP_MS   = 0.4;
    localparam int  PU_CYC = int'(SOFT_RESTART_DELAY_MS * 1000.0 * CLK_MHZ);
    // measurement active time in ms
    localparam real MEAS_MS  = 40.0;
    localparam int  MEAS_CYC = int'(MEAS_MS * 1000.0 * CLK_MHZ);
    // sampling intervals in s for the two power modes
    localparam real LP_INTERVAL_S  = 2.0;
    localparam real ULP_INTERVAL_S = 30.0;
    localparam int  LP_CYC  = int'(LP_INTERVAL_S * 1000000.0 * CLK_MHZ);
    localparam int  ULP_CYC = int'(ULP_INTERVAL_S * 1000000.0 * CLK_MHZ);
    // bus framing
    localparam logic [6:0]  TARGET_ADDR   = 7'h58;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;
    localparam logic [2:0]  WB_ADDR       = 3'h0;
    localparam logic [2:0]  WB_CMD_LO     = 3'h2;
    localparam logic [2:0]  WB_DATA_LO    = 3'h4;
    localparam logic [2:0]  WB_CRC        = 3'h5;
    localparam logic [1:0]  RB_HI         = 2'h0;
    localparam logic [1:0]  RB_LO         = 2'h1;
    localparam logic [1:0]  RB_CRC        = 2'h2;
    localparam logic [7:0]  FILL_BYTE     = 8'hff;
    // command codes, each with its own 3-bit check inside
    localparam logic [15:0] CMD_INIT      = 16'h20ae;
    localparam logic [15:0] CMD_MEASURE   = 16'h2008;
    localparam logic [15:0] CMD_MODE      = 16'h2000;
    // mode-select data words
    localparam logic [15:0] MODE_ULP      = 16'h0000;
    localparam logic [15:0] MODE_LP       = 16'h0001;
    // crc settings until confirmed
    localparam logic [7:0]  CRC_POLY      = 8'h31;
    localparam logic [7:0]  CRC_INIT      = 8'hff;
    // byte engine states
    typedef enum logic [2:0] {
        GSICT_IDLE, GSICT_RX, GSICT_ACK, GSICT_TX, GSICT_MACK, GSICT_SKIP
    } gsict_state_t;
endpackage

// *** design/gsict_top.sv ***
// i2c command target of a gas sensor, with its crc helper
`timescale 1ns/1ps
`default_nettype none

// crc over one 16-bit word, polynomial set by parameter
module gsict_crc8 #(
    parameter logic [7:0] POLY = 8'h31, // generator polynomial
    parameter logic [7:0] INIT = 8'hff  // start value
) (
    input  wire logic [15:0] word,     // data word, msb first
    output logic      [7:0]  crc       // check byte
);
    // bitwise long division, msb first
    always_comb begin
        logic [7:0] c;
        c = INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ word[i]) ? ((c << 1) ^ POLY) : (c << 1);
        end
        crc = c;
    end
endmodule

// Notes on behaviour
// - idle within 0.6 ms, commands only then
// - 16-bit commands carry own 3-bit check
// - every data word followed by crc byte
// - written word discarded on crc mismatch
// - answer only target address 0x58
// - transactions framed by start and stop
// - ack by low sda after 8th fall
// - measurement starts at second command ack
// - busy measurement: every access not acknowledged
// - read returns words msb first, crc
// - no master ack: stop driving, release
// - truncated reads accepted without error
// - result once, excess bytes all ones
// - low-power 2s, ultra-low 30s, default low
// - mode-select with 0x0000 selects ultra-low
// - restart or 0x0001 returns low-power
// - measurement active 40 ms, then sleep
// - init 0x20ae, measure 0x2008 codes
module gsict_top
    import gsict_pkg::*;
#(
    parameter int PU_CYCLES   = gsict_pkg::PU_CYC,   // power-up delay
    parameter int MEAS_CYCLES = gsict_pkg::MEAS_CYC, // measurement time
    parameter int LP_CYCLES   = gsict_pkg::LP_CYC,   // low-power interval
    parameter int ULP_CYCLES  = gsict_pkg::ULP_CYC   // ultra-low interval
) (
    input  wire logic        core_clk,      // core clock
    input  wire logic        arst_n,        // async reset, active low
    input  wire logic        ce,            // clock enable
    input  wire logic        soft_reset,    // restart pulse, same domain
    input  wire logic        scl_i,         // bus clock pin level
    input  wire logic        sda_i,         // bus data pin level
    output logic             sda_o,         // data drive value
    output logic             sda_oe_n,      // data drive enable, low drives
    input  wire logic [15:0] result_word,   // measured value to report
    output logic             ready,         // power-up or restart delay over
    output logic             meas_start,    // measurement start pulse
    output logic             meas_active,   // measurement running
    output logic             algo_start,    // algorithm start pulse
    output logic             ulp_mode,      // ultra-low-power selected
    output logic             sample_tick    // sampling interval pulse
);
    import gsict_pkg::*;

    logic [2:0]   scl_s_q;                  // scl synchroniser
    logic [2:0]   sda_s_q;                  // sda synchroniser
    logic         scl_f_q;                  // filtered scl
    logic         sda_f_q;                  // filtered sda
    gsict_state_t st_q;                     // byte engine state
    logic [3:0]   bit_q;                    // bit count in byte
    logic [7:0]   sh_q;                     // shift register
    logic [2:0]   wb_q;                     // written byte index
    logic [1:0]   rb_q;                     // read byte index
    logic         rw_q;                     // header direction
    logic         drv_q;                    // pulling sda low
    logic [7:0]   cmd_hi_q;                 // command high byte
    logic [15:0]  cmd_q;                    // decoded command
    logic [7:0]   dat_hi_q;                 // data high byte
    logic [15:0]  dat_q;                    // received data word
    logic [31:0]  pu_cnt_q;                 // power-up countdown
    logic [31:0]  meas_cnt_q;               // measurement countdown
    logic [31:0]  int_cnt_q;                // interval countdown
    logic [15:0]  res_q;                    // latched result
    logic         res_vld_q;                // result not yet read
    logic         rd_ok_q;                  // this read has data
    logic         ulp_q;                    // power mode
    logic         start_q;                  // meas start pulse
    logic         algo_q;                   // algo start pulse
    logic         tick_q;                   // interval pulse
    logic         mack_q;                   // sampled master ack bit
    logic [7:0]   crc_wr;                   // crc of written word
    logic [7:0]   crc_rd;                   // crc of result word

    // filtered edges and bus conditions
    wire scl_agree = (scl_s_q[1] == scl_s_q[2]);
    wire sda_agree = (sda_s_q[1] == sda_s_q[2]);
    wire scl_nx    = scl_agree ? scl_s_q[2] : scl_f_q;
    wire sda_nx    = sda_agree ? sda_s_q[2] : sda_f_q;
    wire scl_rise  = scl_nx & ~scl_f_q;
    wire scl_fall  = ~scl_nx & scl_f_q;
    wire bus_start = scl_f_q & scl_nx & sda_f_q & ~sda_nx;
    wire bus_stop  = scl_f_q & scl_nx & ~sda_f_q & sda_nx;

    // status decode
    wire pu_busy   = (pu_cnt_q != 32'h0);
    wire meas_busy = (meas_cnt_q != 32'h0);
    wire meas_end  = (meas_cnt_q == 32'h1);
    wire byte_done = scl_fall & (st_q == GSICT_RX) & (bit_q == BYTE_BITS);
    wire addr_hit  = (sh_q[7:1] == TARGET_ADDR);
    wire addr_ok   = addr_hit & ~pu_busy & ~meas_busy;
    wire hdr_byte  = (wb_q == WB_ADDR);
    wire ack_now   = byte_done & (hdr_byte ? addr_ok : 1'b1);
    wire cmd_done  = byte_done & (wb_q == WB_CMD_LO);
    wire [15:0] cmd_nx = {cmd_hi_q, sh_q};
    wire is_meas   = cmd_done & (cmd_nx == CMD_MEASURE);
    wire is_init   = cmd_done & (cmd_nx == CMD_INIT);
    wire crc_done  = byte_done & (wb_q == WB_CRC);
    wire crc_ok    = (sh_q == crc_wr);
    wire mode_wr   = crc_done & crc_ok & (cmd_q == CMD_MODE);
    wire go_ulp    = mode_wr & (dat_q == MODE_ULP);
    wire go_lp     = mode_wr & (dat_q == MODE_LP);
    wire rd_hdr    = byte_done & hdr_byte & addr_ok & sh_q[0];
    wire mack_ok   = ~mack_q;

    // crc engines for write check and read answer
    gsict_crc8 #(.POLY(CRC_POLY), .INIT(CRC_INIT)) u_crc_wr (
        .word (dat_q),
        .crc  (crc_wr)
    );
    gsict_crc8 #(.POLY(CRC_POLY), .INIT(CRC_INIT)) u_crc_rd (
        .word (res_q),
        .crc  (crc_rd)
    );

    // byte to send: data msb first, crc, then fill
    wire [7:0] tx_word = (rb_q == RB_HI)  ? res_q[15:8] :
                         (rb_q == RB_LO)  ? res_q[7:0]  :
                         (rb_q == RB_CRC) ? crc_rd      : FILL_BYTE;
    wire [7:0] tx_byte = rd_ok_q ? tx_word : FILL_BYTE;

    // outputs
    assign sda_o       = 1'b0;
    assign sda_oe_n    = ~drv_q;
    assign ready       = ~pu_busy;
    assign meas_start  = start_q;
    assign meas_active = meas_busy;
    assign algo_start  = algo_q;
    assign ulp_mode    = ulp_q;
    assign sample_tick = tick_q;

    // pin synchronisers and agreement filter
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else if (ce) begin
            scl_s_q <= {scl_s_q[1:0], scl_i};
            sda_s_q <= {sda_s_q[1:0], sda_i};
            scl_f_q <= scl_nx;
            sda_f_q <= sda_nx;
        end
    end

    // power-up and soft restart countdown
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pu_cnt_q <= 32'(PU_CYCLES);
        end else if (ce) begin
            if (soft_reset) begin
                pu_cnt_q <= 32'(PU_CYCLES);
            end else if (pu_busy) begin
                pu_cnt_q <= pu_cnt_q - 32'h1;
            end
        end
    end

    // measurement timer and result hand-off
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meas_cnt_q <= 32'h0;
            res_q      <= 16'h0;
            res_vld_q  <= 1'b0;
            start_q    <= 1'b0;
        end else if (ce) begin
            start_q <= is_meas;
            if (soft_reset) begin
                meas_cnt_q <= 32'h0;
                res_vld_q  <= 1'b0;
            end else if (is_meas) begin
                meas_cnt_q <= 32'(MEAS_CYCLES);
                res_vld_q  <= 1'b0;
            end else if (meas_end) begin
                meas_cnt_q <= 32'h0;
                res_q      <= result_word;
                res_vld_q  <= 1'b1;
            end else if (meas_busy) begin
                meas_cnt_q <= meas_cnt_q - 32'h1;
            end else if (rd_hdr) begin
                res_vld_q  <= 1'b0;
            end
        end
    end

    // power mode and sampling interval
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ulp_q     <= 1'b0;
            int_cnt_q <= 32'h0;
            tick_q    <= 1'b0;
            algo_q    <= 1'b0;
        end else if (ce) begin
            algo_q <= is_init;
            tick_q <= (int_cnt_q == 32'h1);
            if (soft_reset || go_lp) begin
                ulp_q <= 1'b0;
            end else if (go_ulp) begin
                ulp_q <= 1'b1;
            end
            if (int_cnt_q <= 32'h1) begin
                int_cnt_q <= ulp_q ? 32'(ULP_CYCLES) : 32'(LP_CYCLES);
            end else begin
                int_cnt_q <= int_cnt_q - 32'h1;
            end
        end
    end

    // write-side byte capture
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_hi_q <= 8'h0;
            cmd_q    <= 16'h0;
            dat_hi_q <= 8'h0;
            dat_q    <= 16'h0;
        end else if (ce && byte_done) begin
            case (wb_q)
                WB_CMD_LO - 3'h1: cmd_hi_q <= sh_q;
                WB_CMD_LO:        cmd_q    <= cmd_nx;
                WB_DATA_LO - 3'h1: dat_hi_q <= sh_q;
                WB_DATA_LO:       dat_q    <= {dat_hi_q, sh_q};
                default:          cmd_hi_q <= cmd_hi_q;
            endcase
        end
    end

    // bit and byte engine
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q    <= GSICT_IDLE;
            bit_q   <= 4'h0;
            sh_q    <= 8'h0;
            wb_q    <= 3'h0;
            rb_q    <= 2'h0;
            rw_q    <= 1'b0;
            drv_q   <= 1'b0;
            rd_ok_q <= 1'b0;
            mack_q  <= 1'b1;
        end else if (ce) begin
            if (bus_start) begin
                st_q  <= GSICT_RX;
                bit_q <= 4'h0;
                wb_q  <= WB_ADDR;
                drv_q <= 1'b0;
            end else if (bus_stop) begin
                st_q  <= GSICT_IDLE;
                drv_q <= 1'b0;
            end else begin
                case (st_q)
                    GSICT_RX: begin
                        if (scl_rise) begin
                            sh_q  <= {sh_q[6:0], sda_nx}; // level seen with the edge
                            bit_q <= bit_q + 4'h1;
                        end else if (byte_done) begin
                            bit_q <= 4'h0;
                            if (ack_now) begin
                                st_q  <= GSICT_ACK;
                                drv_q <= 1'b1;
                            end else begin
                                st_q  <= GSICT_SKIP;
                            end
                            if (hdr_byte) begin
                                rw_q    <= sh_q[0];
                                rb_q    <= RB_HI;
                                rd_ok_q <= res_vld_q;
                            end
                            if (wb_q != WB_CRC) begin
                                wb_q <= wb_q + 3'h1;
                            end
                        end
                    end
                    GSICT_ACK: begin
                        if (scl_fall && rw_q) begin
                            st_q  <= GSICT_TX;
                            drv_q <= ~tx_byte[7];
                            sh_q  <= {tx_byte[6:0], 1'b1};
                            bit_q <= 4'h1;
                        end else if (scl_fall) begin
                            st_q  <= GSICT_RX;
                            drv_q <= 1'b0;
                        end
                    end
                    GSICT_TX: begin
                        if (scl_fall && bit_q == BYTE_BITS) begin
                            st_q  <= GSICT_MACK;
                            drv_q <= 1'b0;
                            if (rb_q != RB_CRC + 2'h1) begin
                                rb_q <= rb_q + 2'h1;
                            end
                        end else if (scl_fall) begin
                            drv_q <= ~sh_q[7];
                            sh_q  <= {sh_q[6:0], 1'b1};
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                    GSICT_MACK: begin
                        if (scl_rise) begin
                            mack_q <= sda_nx;
                        end else if (scl_fall && mack_ok) begin
                            st_q  <= GSICT_TX;
                            drv_q <= ~tx_byte[7];
                            sh_q  <= {tx_byte[6:0], 1'b1};
                            bit_q <= 4'h1;
                        end else if (scl_fall) begin
                            st_q  <= GSICT_SKIP;
                        end
                    end
                    GSICT_SKIP: begin
                        drv_q <= 1'b0;
                    end
                    default: begin
                        drv_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // checks on the bus, timer and mode behaviour
    a_no_ack_early: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (pu_busy && !soft_reset) |-> ##1 (st_q != GSICT_ACK) || !drv_q
    ) else $error("acknowledge before idle");

    a_ack_addr_only: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (ce && byte_done && hdr_byte && !addr_hit && !bus_start) |=> !drv_q
    ) else $error("foreign address acknowledged");

    a_ack_slot_drv: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (ce && ack_now && !bus_start && !bus_stop) |=> drv_q && st_q == GSICT_ACK
    ) else $error("good byte not acknowledged");

    a_meas_on_ack: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        $rose(start_q) |-> drv_q && meas_busy
    ) else $error("measurement start not tied to acknowledge");

    a_busy_nack_hdr: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (ce && meas_busy && byte_done && hdr_byte && !bus_start) |=> !drv_q [*2]
    ) else $error("header acknowledged while busy");

    a_nack_release: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (ce && st_q == GSICT_MACK && scl_fall && !mack_ok && !bus_start)
            |=> st_q == GSICT_SKIP && !drv_q
    ) else $error("sda held after not-acknowledge");

    a_result_once: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (ce && rd_hdr && !meas_end && !soft_reset) |=> !res_vld_q
    ) else $error("result offered twice");

    a_mode_restart: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (ce && (soft_reset || go_lp)) |=> !ulp_q
    ) else $error("low-power mode not restored");

    a_mode_ulp_sel: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (ce && go_ulp && !soft_reset) |=> ulp_q
    ) else $error("ultra-low mode not selected");

    a_meas_length: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        $rose(meas_busy) |-> meas_cnt_q == 32'(MEAS_CYCLES)
    ) else $error("measurement time wrong");

    a_crc_discard: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (ce && crc_done && !crc_ok && !soft_reset) |=> $stable(ulp_q)
    ) else $error("bad crc word used");
endmodule

`default_nettype wire

// *** verif/gsict_master.sv ***
// i2c bus master model for the gas sensor bench
`timescale 1ns/1ps
`default_nettype none
module gsict_master (
    input  wire logic core_clk, // paces the bus
    output logic      scl,      // bus clock, idle high
    output logic      sda_rel,  // low pulls sda low
    input  wire logic sda       // resolved sda level
);
    localparam int Q = 2; // core cycles per quarter bit, 320 ns bus period
    // both lines released at power-up
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // wait whole core cycles
    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one bit: sda set mid-low, sampled mid-high
    task automatic slot(input logic b, output logic s);
        w(Q);
        sda_rel <= b;
        w(Q);
        scl <= 1'b1;
        w(Q);
        s = sda;
        w(Q);
        scl <= 1'b0;
    endtask
    // start or repeated start: sda falls under high scl
    task automatic start_cond();
        sda_rel <= 1'b1;
        w(Q);
        scl <= 1'b1;
        w(2 * Q);
        sda_rel <= 1'b0;
        w(2 * Q);
        scl <= 1'b0;
    endtask
    // stop: sda rises under high scl, then bus left idle
    task automatic stop_cond();
        w(Q);
        sda_rel <= 1'b0;
        w(Q);
        scl <= 1'b1;
        w(2 * Q);
        sda_rel <= 1'b1;
        w(2 * Q);
    endtask
    // byte out msb first, then the target's ack slot
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(b[i], s);
        end
        slot(1'b1, s);
        ack = ~s;
    endtask
    // byte in msb first, then our ack or not-ack
    task automatic rd_byte(input logic ack_it, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, s);
            b[i] = s;
        end
        slot(~ack_it, s);
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the gas sensor i2c command target
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gsict_pkg::*;
    localparam int PU = 400;   // shortened power-up delay
    localparam int MEAS = 600; // shortened busy time
    localparam int LP = 100;   // shortened low-power interval
    localparam int ULP = 300;  // shortened ultra-low interval
    localparam logic [7:0] WR = {TARGET_ADDR, 1'b0}; // write header
    localparam logic [7:0] RD = {TARGET_ADDR, 1'b1}; // read header
    logic        core_clk = 1'b0;        // core clock
    logic        arst_n = 1'b0;          // reset, active low
    logic        soft_reset = 1'b0;      // restart pulse
    logic [15:0] result_word = 16'hbeef; // value to report
    logic        scl, sda_rel, sda_o, sda_oe_n;  // bus side
    logic        ready, meas_start, meas_active; // status
    logic        algo_start, ulp_mode, sample_tick; // status
    wire logic   sda = sda_rel & (sda_oe_n | sda_o); // pulled-up wire
    int num_errors = 0, n_compared = 0, n_meas = 0, n_algo = 0;
    int act_cyc = 0, up_cyc = 0, gap = 0, last_gap = 0;
    gsict_top #(.PU_CYCLES(PU), .MEAS_CYCLES(MEAS), .LP_CYCLES(LP), .ULP_CYCLES(ULP))
        gsict_top_inst (.core_clk(core_clk), .arst_n(arst_n), .ce(1'b1),
        .soft_reset(soft_reset), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .result_word(result_word), .ready(ready),
        .meas_start(meas_start), .meas_active(meas_active), .algo_start(algo_start),
        .ulp_mode(ulp_mode), .sample_tick(sample_tick));
    gsict_master gsict_master_inst (.core_clk(core_clk), .scl(scl), .sda_rel(sda_rel),
        .sda(sda));
    // 25 mhz clock
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    // pulse counts, busy length, start-up time, tick spacing
    always @(posedge core_clk) begin
        n_meas <= n_meas + int'(meas_start === 1'b1);
        n_algo <= n_algo + int'(algo_start === 1'b1);
        act_cyc <= (meas_start === 1'b1) ? 0 : act_cyc + int'(meas_active === 1'b1);
        up_cyc <= soft_reset ? 0 : up_cyc + int'(ready !== 1'b1 && arst_n);
        gap <= (sample_tick === 1'b1) ? 0 : gap + 1;
        if (sample_tick === 1'b1) begin
            last_gap <= gap + 1;
        end
    end
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s %h not %h", $time, m, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // bounded wait on ready or on the busy flag
    task automatic wait_for(input bit busy, input logic v, input int lim);
        for (int i = 0; (busy ? meas_active : ready) !== v; i++) begin
            if (i == lim) begin
                check(16'h0, 16'h1, "wait ran out");
                end_of_test();
            end
            @(posedge core_clk);
        end
    endtask
    // crc over a word, msb first
    function automatic logic [7:0] crc_of(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    // write frame, one ack bit a byte
    task automatic wr_frame(input logic [7:0] b[$], output logic [7:0] a);
        logic k;
        a = 8'h00;
        gsict_master_inst.start_cond();
        foreach (b[i]) begin
            gsict_master_inst.wr_byte(b[i], k);
            a[i] = k;
        end
        gsict_master_inst.stop_cond();
    endtask
    // read frame of n bytes, not-ack on the last
    task automatic rd_frame(input int n, output logic h, output logic [7:0] d[$]);
        logic [7:0] b;
        d = {};
        gsict_master_inst.start_cond();
        gsict_master_inst.wr_byte(RD, h);
        for (int i = 0; i < n; i++) begin
            gsict_master_inst.rd_byte(i < n - 1, b);
            d.push_back(b);
        end
        gsict_master_inst.stop_cond();
    endtask
    // mode select with data word and check byte
    task automatic mode_cmd(input logic [15:0] v, input logic [7:0] c);
        logic [7:0] a;
        wr_frame('{WR, CMD_MODE[15:8], CMD_MODE[7:0], v[15:8], v[7:0], c}, a);
        check(a, 8'h3f, "mode acks");
    endtask
    // start-up delay, refusal before idle, address match
    task automatic t_power();
        logic [7:0] a;
        logic [7:0] bad[4] = '{8'hb2, 8'ha0, 8'hf0, 8'h30};
        check(ready, 1'b0, "early ready");
        wr_frame('{WR}, a);
        check(a, 8'h00, "early header");
        wait_for(0, 1'b1, PU + 20);
        check(16'(up_cyc >= PU - 2 && up_cyc <= PU + 2), 16'h1, "start-up");
        foreach (bad[i]) begin
            wr_frame('{bad[i]}, a);
            check(a, 8'h00, "foreign address");
        end
        $display("power and address done");
    endtask
    // command, busy refusal, word readout, one-shot result
    task automatic t_measure(input logic [15:0] r);
        logic [7:0] a;
        logic [7:0] d[$];
        logic h;
        int n0;
        result_word <= r;
        n0 = n_meas;
        wr_frame('{WR, 8'h20, 8'h09}, a);
        check(16'(n_meas - n0), 16'h0, "bad command code");
        wr_frame('{WR, CMD_MEASURE[15:8], CMD_MEASURE[7:0]}, a);
        check(a, 8'h07, "command acks");
        check(16'(n_meas - n0), 16'h1, "start pulse");
        check(meas_active, 1'b1, "busy");
        wr_frame('{RD}, a);
        check(a, 8'h00, "header while busy");
        wait_for(1, 1'b0, MEAS);
        check(16'(act_cyc >= MEAS - 1 && act_cyc <= MEAS + 1), 16'h1, "busy time");
        rd_frame(5, h, d);
        check(h, 1'b1, "read header");
        check({d[0], d[1]}, r, "result");
        check(d[2], crc_of(r), "result crc");
        check({d[3], d[4]}, 16'hffff, "beyond end");
        rd_frame(3, h, d);
        check({d[0], d[1]} & {d[2], 8'hff}, 16'hffff, "second read");
        $display("measure done");
    endtask
    // read cut short after the first byte
    task automatic t_truncated();
        logic [7:0] a;
        logic [7:0] d[$];
        logic h;
        result_word <= 16'h0481;
        wr_frame('{WR, CMD_MEASURE[15:8], CMD_MEASURE[7:0]}, a);
        wait_for(1, 1'b0, MEAS + 300);
        rd_frame(1, h, d);
        check({h, d[0]}, 9'h104, "cut read");
        check(sda_oe_n, 1'b1, "sda released");
        rd_frame(2, h, d);
        check({d[0], d[1]}, 16'hffff, "result gone");
        $display("truncated done");
    endtask
    // power modes, intervals, init, soft restart
    task automatic t_mode();
        logic [7:0] a;
        repeat (2 * LP + 5) @(posedge core_clk);
        check({ulp_mode, 15'(last_gap)}, {1'b0, 15'(LP)}, "low-power");
        mode_cmd(MODE_ULP, ~crc_of(MODE_ULP));
        check(ulp_mode, 1'b0, "bad crc word");
        mode_cmd(MODE_ULP, crc_of(MODE_ULP));
        check(ulp_mode, 1'b1, "ultra-low");
        repeat (2 * ULP + 5) @(posedge core_clk);
        check(16'(last_gap), 16'(ULP), "ultra-low tick");
        mode_cmd(MODE_LP, crc_of(MODE_LP));
        check(ulp_mode, 1'b0, "back to low");
        mode_cmd(MODE_ULP, crc_of(MODE_ULP));
        wr_frame('{WR, CMD_INIT[15:8], CMD_INIT[7:0]}, a);
        check({ulp_mode, 15'(n_algo)}, 16'h8001, "init");
        soft_reset <= 1'b1;
        @(posedge core_clk);
        soft_reset <= 1'b0;
        repeat (2) @(posedge core_clk);
        check({ready, ulp_mode}, 2'b00, "restart");
        wait_for(0, 1'b1, PU + 20);
        check(16'(up_cyc >= PU - 2 && up_cyc <= PU + 2), 16'h1, "restart time");
        $display("mode done");
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        t_power();
        t_measure(16'hbeef);
        t_measure(16'h7f01);
        t_truncated();
        t_mode();
        end_of_test();
    end
endmodule
`default_nettype wire
